// ===== pkg/tpc_pkg.sv
// Constants, register layouts and carrier types of the timer block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package tpc_pkg;
    localparam int unsigned NCH   = 5;
    localparam int unsigned NSM   = 2;
    localparam int unsigned NPIN  = NCH + 1 + NSM;
    localparam int unsigned ADR_W = 8;

    localparam logic [7:0] A_MCTRL = 8'h00;
    localparam logic [7:0] A_MPER  = 8'h04;
    localparam logic [7:0] A_MCNT  = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam logic [7:0] A_CHCFG = 8'h10;
    localparam logic [7:0] A_CHCAP = 8'h30;
    localparam logic [7:0] A_SCFG  = 8'h50;
    localparam logic [7:0] A_SCNT  = 8'h58;
    localparam logic [7:0] A_STEP  = 8'h04;

    // Status word: channel flags low, small-timer flags, main wrap flag
    localparam int unsigned ST_SM  = NCH;
    localparam int unsigned ST_OVF = NCH + NSM;
    localparam int unsigned ST_W   = ST_OVF + 1;

    localparam logic [15:0] MPER_RST = 16'hFFFF;
    localparam logic [7:0]  SPER_RST = 8'hFF;

    typedef enum logic [1:0] {
        TPC_EDGE_NONE,
        TPC_EDGE_RISE,
        TPC_EDGE_FALL,
        TPC_EDGE_BOTH
    } tpc_edge_t;

    typedef struct packed {
        logic [15:0] rsv1;
        logic [7:0]  presc;
        logic [4:0]  rsv0;
        logic        ir;
        logic        ext;
        logic        en;
    } tpc_mctrl_t;

    typedef struct packed {
        logic [12:0] rsv;
        tpc_edge_t   edge_sel;
        logic        pwm;
        logic [15:0] cmp;
    } tpc_chcfg_t;

    typedef struct packed {
        logic [7:0] cmp;
        logic [7:0] per;
        logic [7:0] presc;
        logic [5:0] rsv;
        logic       ext;
        logic       en;
    } tpc_scfg_t;

    localparam tpc_scfg_t SCFG_RST = '{cmp: 8'h00, per: SPER_RST, presc: 8'h00,
                                      rsv: 6'h00, ext: 1'b0, en: 1'b0};
endpackage

// ===== design/tpc_timer.sv
// Timer block: 16-bit main timer with five compare/capture channels,
// two 8-bit timers with one PWM channel each, IR modulation output.
// Assumes a classic Wishbone master on clk and asynchronous pin inputs.
// Operation
// - 16-bit main counter: timer, counter, PWM
// - Prescaler and 16-bit period bound main count
// - Five channels, each own 16-bit compare
// - Channel selects PWM output or edge capture
// - IR mode: count small timer periods, AND
// - Two 8-bit timers: prescaler, period, modes
// - One 8-bit compare PWM channel each
// - Capture inputs pass two-stage synchroniser
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer
    import tpc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NCH-1:0]    cap_in,
    input  wire logic              m_cnt_in,
    input  wire logic [NSM-1:0]    sm_cnt_in,
    output logic [NCH-1:0]         pwm_out,
    output logic [NSM-1:0]         sm_pwm_out,
    output logic                   ir_out
);
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic edge_hit(input tpc_edge_t s, input logic r, input logic f);
        return ((s == TPC_EDGE_RISE) && r) || ((s == TPC_EDGE_FALL) && f) ||
               ((s == TPC_EDGE_BOTH) && (r || f));
    endfunction

    // Bus slave: ack one cycle after the request, write on the ack edge
    logic        ack_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    wire         req = wb_cyc_i & wb_stb_i;
    wire         wr  = req & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            rd_q  <= rd_d;
        end
    end

    wire hit_mctrl = wb_adr_i == A_MCTRL;
    wire hit_mper  = wb_adr_i == A_MPER;
    wire hit_mcnt  = wb_adr_i == A_MCNT;
    wire hit_stat  = wb_adr_i == A_STAT;

    // Pin synchroniser; a pulse of 1.5 clock periods is always sampled
    logic [NPIN-1:0] s1_q, s2_q, prev_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q   <= '0;
            s2_q   <= '0;
            prev_q <= '0;
        end else begin
            s1_q   <= {sm_cnt_in, m_cnt_in, cap_in};
            s2_q   <= s1_q;
            prev_q <= s2_q;
        end
    end
    wire [NPIN-1:0] rise = s2_q & ~prev_q;
    wire [NPIN-1:0] fall = ~s2_q & prev_q;

    // Small timers
    tpc_scfg_t      scfg_q [NSM];
    logic [7:0]     scnt_q [NSM];
    logic [7:0]     sps_q  [NSM];
    logic [NSM-1:0] sm_done, sm_evt, sm_pwm_d, sm_tick, shit_cfg, shit_cnt;

    for (genvar j = 0; j < NSM; j++) begin : g_sm
        wire       pt   = sps_q[j] == scfg_q[j].presc;
        wire [7:0] cnxt = sm_done[j] ? 8'h00 : scnt_q[j] + 8'(sm_tick[j]);
        assign shit_cfg[j] = wb_adr_i == 8'(A_SCFG + A_STEP * j);
        assign shit_cnt[j] = wb_adr_i == 8'(A_SCNT + A_STEP * j);
        assign sm_tick[j]  = scfg_q[j].en &
                             (scfg_q[j].ext ? rise[NCH + 1 + j] : pt);
        assign sm_done[j]  = sm_tick[j] & (scnt_q[j] == scfg_q[j].per);
        assign sm_evt[j]   = sm_tick[j] & (scnt_q[j] == scfg_q[j].cmp);
        assign sm_pwm_d[j] = scfg_q[j].en & (cnxt < scfg_q[j].cmp);

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                scfg_q[j]     <= SCFG_RST;
                scnt_q[j]     <= 8'h00;
                sps_q[j]      <= 8'h00;
                sm_pwm_out[j] <= 1'b0;
            end else begin
                if (wr && shit_cfg[j]) begin
                    scfg_q[j]     <= wmerge(scfg_q[j], wb_dat_i, wb_sel_i);
                    scfg_q[j].rsv <= '0;
                end
                sps_q[j]      <= (pt || !scfg_q[j].en) ? 8'h00 : sps_q[j] + 8'h01;
                scnt_q[j]     <= (wr && shit_cnt[j]) ? 8'h00 : cnxt;
                sm_pwm_out[j] <= sm_pwm_d[j];
            end
        end
    end

    // Main timer
    tpc_mctrl_t  mctrl_q;
    logic [15:0] mper_q, mcnt_q, mps_q;
    wire         m_pt   = mps_q[7:0] == mctrl_q.presc;
    wire         m_tick = mctrl_q.en & (mctrl_q.ir ? sm_done[0] :
                          mctrl_q.ext ? rise[NCH] : m_pt);
    wire         m_wrap = m_tick & (mcnt_q == mper_q);
    wire [15:0]  m_cnxt = m_wrap ? 16'h0000 : mcnt_q + 16'(m_tick);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mctrl_q <= '0;
            mper_q  <= MPER_RST;
            mcnt_q  <= 16'h0000;
            mps_q   <= 16'h0000;
        end else begin
            if (wr && hit_mctrl) begin
                mctrl_q      <= wmerge(mctrl_q, wb_dat_i, wb_sel_i);
                mctrl_q.rsv0 <= '0;
                mctrl_q.rsv1 <= '0;
            end
            if (wr && hit_mper) begin
                mper_q <= 16'(wmerge({16'h0000, mper_q}, wb_dat_i, wb_sel_i));
            end
            mps_q  <= (m_pt || !mctrl_q.en) ? 16'h0000 : mps_q + 16'h0001;
            mcnt_q <= (wr && hit_mcnt) ? 16'h0000 : m_cnxt;
        end
    end

    // Compare/capture channels
    tpc_chcfg_t     ccfg_q [NCH];
    logic [15:0]    ccap_q [NCH];
    logic [NCH-1:0] ch_evt, ch_cap, chit_cfg, chit_cap, pwm_d;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        assign chit_cfg[i] = wb_adr_i == 8'(A_CHCFG + A_STEP * i);
        assign chit_cap[i] = wb_adr_i == 8'(A_CHCAP + A_STEP * i);
        assign ch_cap[i]   = ~ccfg_q[i].pwm &
                             edge_hit(ccfg_q[i].edge_sel, rise[i], fall[i]);
        assign ch_evt[i]   = ch_cap[i] |
                             (ccfg_q[i].pwm & m_tick & (mcnt_q == ccfg_q[i].cmp));
        assign pwm_d[i]    = ccfg_q[i].pwm & mctrl_q.en & (m_cnxt < ccfg_q[i].cmp);

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ccfg_q[i]  <= '0;
                ccap_q[i]  <= 16'h0000;
                pwm_out[i] <= 1'b0;
            end else begin
                if (wr && chit_cfg[i]) begin
                    ccfg_q[i]     <= wmerge(ccfg_q[i], wb_dat_i, wb_sel_i);
                    ccfg_q[i].rsv <= '0;
                end
                if (ch_cap[i]) begin
                    ccap_q[i] <= mcnt_q;
                end
                pwm_out[i] <= pwm_d[i];
            end
        end
    end

    // Sticky flags, write one to clear; a same-cycle event wins
    logic [ST_W-1:0] stat_q;
    wire  [ST_W-1:0] st_set = {m_wrap, sm_evt, ch_evt};
    wire  [ST_W-1:0] st_clr = (wr && hit_stat) ? wb_dat_i[ST_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
            ir_out <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~st_clr) | st_set;
            ir_out <= mctrl_q.ir & pwm_d[0] & sm_pwm_d[0];
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_mctrl) begin
            rd_d = mctrl_q;
        end else if (hit_mper) begin
            rd_d = {16'h0000, mper_q};
        end else if (hit_mcnt) begin
            rd_d = {16'h0000, mcnt_q};
        end else if (hit_stat) begin
            rd_d = 32'(stat_q);
        end
        for (int k = 0; k < NCH; k++) begin
            if (chit_cfg[k]) begin
                rd_d = ccfg_q[k];
            end else if (chit_cap[k]) begin
                rd_d = {16'h0000, ccap_q[k]};
            end
        end
        for (int k = 0; k < NSM; k++) begin
            if (shit_cfg[k]) begin
                rd_d = scfg_q[k];
            end else if (shit_cnt[k]) begin
                rd_d = {24'h00_0000, scnt_q[k]};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_cnt_step;
        m_tick && !m_wrap && !(wr && hit_mcnt) |=> mcnt_q == $past(mcnt_q) + 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("main count step");
    property p_wrap;
        m_wrap && !(wr && hit_mcnt) |=> mcnt_q == 16'h0000 && stat_q[ST_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("main wrap");
    property p_presc;
        mctrl_q.en && !mctrl_q.ir && !mctrl_q.ext && m_tick && !(wr && hit_mctrl) |=>
            mps_q == 16'h0000 && m_tick == (mctrl_q.presc == 8'h00);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler tick");
    property p_cfg_wr;
        wr && chit_cfg[0] && wb_sel_i[1:0] == 2'h3 |=> ccfg_q[0].cmp == $past(wb_dat_i[15:0]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("compare write");
    property p_cap;
        ch_cap[1] |=> ccap_q[1] == $past(mcnt_q) && stat_q[1];
    endproperty
    a_cap: assert property (p_cap) else $error("capture latch");
    property p_pwm;
        ccfg_q[2].pwm && mctrl_q.en && !(wr && hit_mcnt) ##1 ccfg_q[2].pwm && mctrl_q.en |->
            pwm_out[2] == (mcnt_q < $past(ccfg_q[2].cmp));
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm level");
    property p_ir;
        ##1 ir_out |-> pwm_out[0] && sm_pwm_out[0] && $past(mctrl_q.ir);
    endproperty
    a_ir: assert property (p_ir) else $error("ir gating");
    property p_ir_tick;
        mctrl_q.en && mctrl_q.ir && !sm_done[0] && !(wr && hit_mcnt) |=> $stable(mcnt_q);
    endproperty
    a_ir_tick: assert property (p_ir_tick) else $error("ir period count");
    property p_sm_wrap;
        sm_done[1] && !(wr && shit_cnt[1]) |=> scnt_q[1] == 8'h00 &&
            sm_pwm_out[1] == $past(scfg_q[1].en && scfg_q[1].cmp != 8'h00);
    endproperty
    a_sm_wrap: assert property (p_sm_wrap) else $error("small wrap");
    property p_sm_pwm;
        scfg_q[0].en && !(wr && shit_cnt[0]) |=>
            sm_pwm_out[0] == (scnt_q[0] < $past(scfg_q[0].cmp));
    endproperty
    a_sm_pwm: assert property (p_sm_pwm) else $error("small pwm level");
    property p_sm_flag;
        sm_evt[0] |=> stat_q[ST_SM];
    endproperty
    a_sm_flag: assert property (p_sm_flag) else $error("small compare flag");
    property p_sync;
        ##2 s2_q == $past({sm_cnt_in, m_cnt_in, cap_in}, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser depth");
    property p_ack;
        req && !ack_q |=> ack_q ##1 !ack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing");
    c_cap:  cover property (ch_cap[0] ##1 stat_q[0]);
    c_wrap: cover property (m_wrap);
    c_ir:   cover property (ir_out ##1 !ir_out);
    c_sm:   cover property (sm_done[1] && sm_evt[1]);
endmodule
`default_nettype wire

// ===== verif/tpc_timer_test.sv
// Self-checking bench of the timer block: bus, capture, PWM, IR output.
// Assumes a one-cycle registered Wishbone ack and the package register map.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_test import tpc_pkg::*;;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              cyc = 1'b0;
    logic              stb = 1'b0;
    logic              we = 1'b0;
    logic [ADR_W-1:0]  adr = '0;
    logic [3:0]        sel = 4'h0;
    logic [31:0]       dat = '0;
    logic [NCH-1:0]    cap = '0;
    logic              mcnt = 1'b0;
    logic [NSM-1:0]    smcnt = '0;
    logic [31:0]       rdat;
    logic              ack;
    logic [NCH-1:0]    pwm;
    logic [NSM-1:0]    spwm;
    logic              ir;
    logic [31:0]       q_exp[$];
    logic [31:0]       q_msk[$];
    int                err_total = 0;
    int                tests_run = 0;
    int                ticks = 0;
    int                hi[8];
    int                n_ext;
    logic [31:0]       rnd = 32'h2026;
    logic [15:0]       cmp[NCH];
    logic [7:0]        scmp;

    always #50 clk = ~clk;

    tpc_timer uut (
        .clk        (clk),
        .arst_n     (arst_n),
        .wb_cyc_i   (cyc),
        .wb_stb_i   (stb),
        .wb_we_i    (we),
        .wb_adr_i   (adr),
        .wb_sel_i   (sel),
        .wb_dat_i   (dat),
        .wb_dat_o   (rdat),
        .wb_ack_o   (ack),
        .cap_in     (cap),
        .m_cnt_in   (mcnt),
        .sm_cnt_in  (smcnt),
        .pwm_out    (pwm),
        .sm_pwm_out (spwm),
        .ir_out     (ir)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until ack is sampled high, then released for a cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q_exp.push_back(e & m);
        q_msk.push_back(m);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
    endtask

    // Counts high cycles; windows are whole periods, so phase does not matter
    task automatic run(input int n);
        hi = '{default: 0};
        repeat (n) begin
            @(posedge clk);
            for (int i = 0; i < NCH; i++)
                hi[i] += int'(pwm[i] === 1'b1);
            hi[5] += int'(spwm[0] === 1'b1);
            hi[6] += int'(spwm[1] === 1'b1);
            hi[7] += int'(ir === 1'b1);
        end
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && q_exp.size() > 0) begin
            check("rdata", rdat & q_msk[0], q_exp[0]);
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end
    end

    always @(posedge clk) begin
        ticks++;
        if (ticks == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(A_MPER, {16'h0000, MPER_RST}, ALL);
        rd(A_SCFG, SCFG_RST, ALL);
        rd(A_STAT, 32'h0000_0000, ALL);
        bus(1'b1, A_MPER, 32'h0000_1234, 4'h1);
        rd(A_MPER, 32'h0000_FF34, ALL);
        wr(A_MCTRL, 32'hFFFF_FF00);
        rd(A_MCTRL, 32'h0000_FF00, ALL);
        wr(8'h7C, ALL);
        rd(8'h7C, 32'h0000_0000, ALL);
        // External edges counted exactly by all three timers, then frozen for capture
        rnd = xs(rnd);
        n_ext = 1 + int'(rnd[3:0]);
        wr(A_MPER, 32'h0000_FFFF);
        wr(A_MCTRL, 32'h0000_0003);
        wr(A_SCFG, 32'h00FF_0003);
        wr(A_SCFG + A_STEP, 32'h00FF_0003);
        repeat (n_ext) begin
            @(posedge clk) {smcnt, mcnt} <= 3'h7;
            repeat (2) @(posedge clk);
            {smcnt, mcnt} <= 3'h0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        wr(A_MCTRL, 32'h0000_0000);
        rd(A_MCNT, n_ext, 32'h0000_FFFF);
        rd(A_SCNT, n_ext, 32'h0000_00FF);
        rd(A_SCNT + A_STEP, n_ext, 32'h0000_00FF);
        // Small counts cleared so the later PWM windows start inside the period
        wr(A_SCNT, ALL);
        wr(A_SCNT + A_STEP, ALL);
        rd(A_SCNT, 32'h0000_0000, 32'h0000_00FF);
        for (int e = 0; e < 4; e++) begin
            wr(A_CHCFG + A_STEP, e << 17);
            wr(A_STAT, ALL);
            @(posedge clk) cap[1] <= 1'b1;
            repeat (6) @(posedge clk);
            rd(A_STAT, {30'h0, e[0], 1'b0}, 32'h0000_0002);
            wr(A_STAT, 32'h0000_0002);
            @(posedge clk) cap[1] <= 1'b0;
            repeat (6) @(posedge clk);
            rd(A_STAT, {30'h0, e[1], 1'b0}, 32'h0000_0002);
            rd(A_CHCAP + A_STEP, (e == 0) ? 0 : n_ext, 32'h0000_FFFF);
        end
        // Five PWM channels with random compares 0 to 10, up to one above the period
        wr(A_MCNT, 32'h0000_0000);
        wr(A_MPER, 32'h0000_0009);
        for (int i = 0; i < NCH; i++) begin
            rnd = xs(rnd);
            cmp[i] = 16'(rnd % 11);
            wr(A_CHCFG + 8'(4 * i), {15'h0000, 1'b1, cmp[i]});
        end
        rnd = xs(rnd);
        scmp = 8'(rnd % 6);
        wr(A_SCFG, 32'h0307_0001);
        wr(A_SCFG + A_STEP, {scmp, 24'h04_0101});
        wr(A_MCTRL, 32'h0000_0001);
        repeat (20) @(posedge clk);
        run(200);
        for (int i = 0; i < NCH; i++)
            check("pwm", hi[i], cmp[i] * 20);
        check("sm0", hi[5], 75);
        check("sm1", hi[6], scmp * 40);
        check("ir_off", hi[7], 0);
        rd(A_STAT, 32'h0000_00A0, 32'h0000_00A0);
        wr(A_MCTRL, 32'h0000_0000);
        wr(A_SCFG, 32'h0000_0000);
        wr(A_SCFG + A_STEP, 32'h0000_0000);
        wr(A_STAT, ALL);
        rd(A_STAT, 32'h0000_0000, 32'h0000_00FF);
        // Main timer steps once per small timer period in IR mode
        wr(A_SCFG, 32'h0203_0001);
        wr(A_MPER, 32'h0000_0004);
        wr(A_CHCFG, 32'h0001_0002);
        wr(A_MCNT, 32'h0000_0000);
        wr(A_MCTRL, 32'h0000_0005);
        repeat (40) @(posedge clk);
        run(200);
        check("ir_ch0", hi[0], 80);
        check("ir", hi[7], 40);
        wrap_up();
    end
endmodule
`default_nettype wire
